/* File: hdl/transceiver_pkg.sv */
// Constants, register map and types for the serial transceiver lane controller.
package transceiver_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] SWING_ADDR = 8'h04;
    localparam logic [7:0] EMPH_ADDR = 8'h08;
    localparam logic [7:0] EQ_ADDR = 8'h0C;
    localparam logic [7:0] STATUS_ADDR = 8'h10;
    localparam logic [7:0] RXWORD_ADDR = 8'h14;

    // Widths and depths.
    localparam int WORD_W = 40;
    localparam int SET_W = 4;
    localparam int CNT_W = 6;
    localparam int TRANS_W = 13;
    localparam int MISS_W = 7;
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int LVL_W = 3;
    localparam int CTRL_W = 6;
    localparam int STATUS_W = 6;

    // Reset values and limits.
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    localparam logic [MISS_W-1:0] MISS_LIMIT = 7'h4B;
    localparam logic [LVL_W-1:0] FIFO_FULL_LVL = 3'h4;
    localparam int LOCK_TRANSITIONS_DEFAULT = 5000;

    // Multiplication factors between the word clock and the bit rate.
    localparam logic [CNT_W-1:0] FACTOR_10 = 6'h0A;
    localparam logic [CNT_W-1:0] FACTOR_16 = 6'h10;
    localparam logic [CNT_W-1:0] FACTOR_20 = 6'h14;
    localparam logic [CNT_W-1:0] FACTOR_32 = 6'h20;
    localparam logic [CNT_W-1:0] FACTOR_40 = 6'h28;

    // Operating modes.
    typedef enum logic [2:0]
    {
        MODE_X10 = 3'b000,
        MODE_X16 = 3'b001,
        MODE_X20 = 3'b010,
        MODE_X32 = 3'b011,
        MODE_X40 = 3'b100
    } mode_t;

    // Control register layout, bit 0 upward: mode, tx invert, rx invert, force reference.
    typedef struct packed
    {
        logic force_ref;
        logic rx_invert;
        logic tx_invert;
        mode_t mode;
    } ctrl_t;

    // Status register layout.
    typedef struct packed
    {
        logic [LVL_W-1:0] fifo_level;
        logic forced_ref;
        logic on_reference;
        logic locked;
    } status_t;

    // Receive lock states.
    typedef enum logic [1:0]
    {
        ST_REF = 2'b00,
        ST_DATA = 2'b01,
        ST_FORCED = 2'b10
    } lock_state_t;

    // Bits per word for a mode; an unknown code falls back to the smallest factor.
    function automatic logic [CNT_W-1:0] mode_factor(input mode_t m);
        case (m)
            MODE_X16: mode_factor = FACTOR_16;
            MODE_X20: mode_factor = FACTOR_20;
            MODE_X32: mode_factor = FACTOR_32;
            MODE_X40: mode_factor = FACTOR_40;
            default: mode_factor = FACTOR_10;
        endcase
    endfunction : mode_factor

endpackage : transceiver_pkg

/* File: hdl/serial_transceiver_lock_ctrl.sv */
// Digital lane controller: transmit FIFO and serializer, deserializer and receive lock control.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module serial_transceiver_lock_ctrl
#(
    parameter int LOCK_TRANSITIONS = transceiver_pkg::LOCK_TRANSITIONS_DEFAULT,
    parameter logic [transceiver_pkg::SET_W-1:0] SWING_INIT = 4'h8,
    parameter logic [transceiver_pkg::SET_W-1:0] EMPH_INIT = 4'h0,
    parameter logic [transceiver_pkg::SET_W-1:0] EQ_INIT = 4'h0
)
(
    // Clock, reset and enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fabric transmit side.
    input wire logic fabric_tx_clock,
    input wire logic [transceiver_pkg::WORD_W-1:0] fabric_tx_data,
    output logic fabric_tx_ready,
    input wire logic tx_line_invert,
    output logic tx_word_clock,
    // Serial line.
    output logic serial_out_pos,
    output logic serial_out_neg,
    input wire logic serial_in_pos,
    input wire logic serial_in_neg,
    // Fabric receive side.
    input wire logic rx_lock_source_select,
    output logic recovered_rx_clock,
    output logic [transceiver_pkg::WORD_W-1:0] rx_word,
    output logic rx_word_valid,
    output logic rx_locked,
    // Analog settings.
    output logic [transceiver_pkg::SET_W-1:0] swing_setting,
    output logic [transceiver_pkg::SET_W-1:0] emphasis_setting,
    output logic [transceiver_pkg::SET_W-1:0] rx_equalizer_setting
);
    import transceiver_pkg::*;

    localparam logic [TRANS_W-1:0] LOCK_LAST = TRANS_W'(LOCK_TRANSITIONS - 1);

    ctrl_t ctrl;
    logic [CNT_W-1:0] factor;
    logic [CNT_W-1:0] half_factor;
    logic apb_done;
    logic [WORD_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [LVL_W-1:0] fifo_level;
    logic [LVL_W-1:0] next_level;
    logic fifo_push;
    logic fifo_pop;
    logic [CNT_W-1:0] tx_bit_cnt;
    logic [WORD_W-1:0] tx_shift;
    logic tx_word_end;
    logic tx_bit;
    logic tx_swap;
    logic rx_bit;
    logic rx_prev;
    logic transition;
    logic [CNT_W-1:0] rx_bit_cnt;
    logic [WORD_W-1:0] rx_shift;
    logic [WORD_W-1:0] rx_assembled;
    logic rx_word_end;
    lock_state_t lock_state;
    lock_state_t next_state;
    logic [TRANS_W-1:0] trans_cnt;
    logic [MISS_W-1:0] miss_cnt;
    logic force_ref;
    status_t status;

    ////////////////////////////////////////////////////////////////////////////
    // Shared decode.

    // Both serializer and deserializer divide by the same mode factor.
    assign factor = mode_factor(ctrl.mode);
    assign half_factor = factor >> 1;
    assign apb_done = psel & penable & pready;
    assign force_ref = rx_lock_source_select | ctrl.force_ref;

    ////////////////////////////////////////////////////////////////////////////
    // APB register file.

    // One wait state: pready rises the cycle after the access phase begins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else if (ce)
            pready <= psel & penable & ~pready;
    end

    // Control, swing, emphasis and equalizer writes take effect at the completing edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= ctrl_t'(CTRL_RESET);
            swing_setting <= SWING_INIT;
            emphasis_setting <= EMPH_INIT;
            rx_equalizer_setting <= EQ_INIT;
        end
        else if (ce && apb_done && pwrite)
        begin
            case (paddr)
                CTRL_ADDR: ctrl <= ctrl_t'(pwdata[CTRL_W-1:0]);
                SWING_ADDR: swing_setting <= pwdata[SET_W-1:0];
                EMPH_ADDR: emphasis_setting <= pwdata[SET_W-1:0];
                EQ_ADDR: rx_equalizer_setting <= pwdata[SET_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data and error are captured on the edge that raises pready, one cycle into the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (psel && penable && !pready)
            begin
                case (paddr)
                    CTRL_ADDR: prdata <= 32'(ctrl);
                    SWING_ADDR: prdata <= 32'(swing_setting);
                    EMPH_ADDR: prdata <= 32'(emphasis_setting);
                    EQ_ADDR: prdata <= 32'(rx_equalizer_setting);
                    STATUS_ADDR: prdata <= 32'(status);
                    RXWORD_ADDR: prdata <= rx_word[31:0];
                    default: pslverr <= 1'b1; // Unmapped addresses answer with an error.
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit FIFO.

    // Fabric presents a word by raising its transmit strobe while ready is high.
    assign fifo_push = fabric_tx_clock & fabric_tx_ready;
    assign fifo_pop = tx_word_end & (fifo_level != '0);
    assign next_level = fifo_level + LVL_W'(fifo_push) - LVL_W'(fifo_pop);

    // Storage and pointers; with matched rates the level hovers at one word.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fifo_level <= '0;
            fabric_tx_ready <= 1'b0;
        end
        else if (ce)
        begin
            if (fifo_push)
            begin
                fifo_mem[wr_ptr] <= fabric_tx_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (fifo_pop)
                rd_ptr <= rd_ptr + 1'b1;
            fifo_level <= next_level;
            fabric_tx_ready <= next_level < FIFO_FULL_LVL; // Ready reflects room after this edge.
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serializer, one bit per clock, least significant bit first.

    assign tx_word_end = tx_bit_cnt >= factor - 1'b1;
    assign tx_bit = tx_shift[0];
    assign tx_swap = ctrl.tx_invert | tx_line_invert;

    // An empty FIFO at a word boundary sends an all-zero word rather than stalling the line.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_bit_cnt <= '0;
            tx_shift <= '0;
            tx_word_clock <= 1'b0;
        end
        else if (ce)
        begin
            if (tx_word_end)
            begin
                tx_bit_cnt <= '0;
                tx_shift <= fifo_pop ? fifo_mem[rd_ptr] : '0;
            end
            else
            begin
                tx_bit_cnt <= tx_bit_cnt + 1'b1;
                tx_shift <= tx_shift >> 1;
            end
            tx_word_clock <= tx_bit_cnt < half_factor;
        end
    end

    // Differential legs; a swap exchanges them rather than touching the data path.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_out_pos <= 1'b0;
            serial_out_neg <= 1'b1;
        end
        else if (ce)
        begin
            serial_out_pos <= tx_swap ? ~tx_bit : tx_bit;
            serial_out_neg <= tx_swap ? tx_bit : ~tx_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Deserializer.

    // Reversed board traces are corrected by reading the other leg.
    assign rx_bit = ctrl.rx_invert ? serial_in_neg : serial_in_pos;
    assign rx_word_end = rx_bit_cnt >= factor - 1'b1;
    assign rx_assembled = ({rx_bit, rx_shift[WORD_W-1:1]}) >> (WORD_W - int'(factor));

    // Word boundary runs on the local divider, so forced mode keeps sampling unchanged.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_bit_cnt <= '0;
            rx_shift <= '0;
            rx_word <= '0;
            rx_word_valid <= 1'b0;
            recovered_rx_clock <= 1'b0;
        end
        else if (ce)
        begin
            rx_shift <= {rx_bit, rx_shift[WORD_W-1:1]};
            rx_word_valid <= rx_word_end;
            if (rx_word_end)
            begin
                rx_bit_cnt <= '0;
                rx_word <= rx_assembled;
            end
            else
                rx_bit_cnt <= rx_bit_cnt + 1'b1;
            recovered_rx_clock <= rx_bit_cnt < half_factor;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive lock control.

    // Edge of the received stream; previous bit is a plain register, not a synchroniser.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_prev <= 1'b0;
        else if (ce)
            rx_prev <= rx_bit;
    end

    assign transition = rx_bit ^ rx_prev;

    // Next lock state; forcing wins over everything and discards data phase.
    always_comb
    begin
        next_state = lock_state;
        case (lock_state)
            ST_REF:
                if (force_ref)
                    next_state = ST_FORCED;
                else if (transition && trans_cnt >= LOCK_LAST)
                    next_state = ST_DATA;
            ST_DATA:
                if (force_ref)
                    next_state = ST_FORCED;
                else if (!transition && miss_cnt >= MISS_LIMIT)
                    next_state = ST_REF;
            ST_FORCED:
                if (!force_ref)
                    next_state = ST_REF;
            default:
                next_state = ST_REF;
        endcase
    end

    // Transition and gap counters; in forced mode they are held clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_state <= ST_REF;
            trans_cnt <= '0;
            miss_cnt <= '0;
        end
        else if (ce)
        begin
            lock_state <= next_state;
            if (next_state == ST_FORCED || next_state != lock_state)
            begin
                trans_cnt <= '0;
                miss_cnt <= '0;
            end
            else if (transition)
            begin
                miss_cnt <= '0;
                if (trans_cnt < LOCK_LAST)
                    trans_cnt <= trans_cnt + 1'b1;
            end
            else if (miss_cnt >= MISS_LIMIT)
            begin
                // Too long a gap while hunting means data went away; start counting afresh.
                trans_cnt <= '0;
                miss_cnt <= '0;
            end
            else
                miss_cnt <= miss_cnt + 1'b1;
        end
    end

    // Lock status follows the next state so it moves on the same edge as the state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_locked <= 1'b0;
        else if (ce)
            rx_locked <= next_state == ST_DATA;
    end

    // Status word for software.
    assign status.fifo_level = fifo_level;
    assign status.forced_ref = lock_state == ST_FORCED;
    assign status.on_reference = lock_state != ST_DATA;
    assign status.locked = rx_locked;

endmodule : serial_transceiver_lock_ctrl

/* File: verif/serial_transceiver_lock_ctrl_asserts.sv */
// Port-level checker for the serial transceiver lane controller.
`timescale 1ns/1ps
module xcvr_lane_checker
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Line and receive status.
    input wire logic serial_out_pos,
    input wire logic serial_out_neg,
    input wire logic serial_in_pos,
    input wire logic rx_lock_source_select,
    input wire logic rx_word_valid,
    input wire logic rx_locked
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    // Run of samples without a transition; saturates so a long idle cannot wrap.
    logic prev_in;
    logic [6:0] miss_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_in <= 1'b0;
            miss_cnt <= 7'h00;
        end
        else
        begin
            prev_in <= serial_in_pos;
            if (serial_in_pos != prev_in)
                miss_cnt <= 7'h00;
            else if (miss_cnt != 7'h7F)
                miss_cnt <= miss_cnt + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The access phase waits exactly one cycle for its answer.
    sequence access_wait;
        psel && penable && !pready;
    endsequence
    apb_wait_a: assert property (access_wait |=> pready)
        else $error("register answer not one cycle after access");
    pready_pulse_a: assert property (pready |-> $past(psel && penable) ##1 !pready)
        else $error("register answer without access or too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag outside an answer");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data not zero outside an answer");
    line_diff_a: assert property (serial_out_neg == !serial_out_pos)
        else $error("output legs not complementary");
    force_unlock_a: assert property (rx_lock_source_select |=> !rx_locked)
        else $error("lock status high while forced to reference");
    lock_edge_a: assert property ($rose(rx_locked) |->
        $past(serial_in_pos) != $past(serial_in_pos, 2) && !$past(rx_lock_source_select))
        else $error("lock rose without a sampled transition");
    lock_hold_a: assert property (rx_locked && !rx_lock_source_select && miss_cnt < 7'h4B
        |=> rx_locked)
        else $error("lock lost within the tolerated gap");
    lock_drop_a: assert property ($fell(rx_locked) && !$past(rx_lock_source_select)
        |-> miss_cnt == 7'h4C)
        else $error("lock dropped at the wrong gap length");
    word_pulse_a: assert property (rx_word_valid |=> !rx_word_valid)
        else $error("word valid longer than one cycle");
endmodule : xcvr_lane_checker

bind serial_transceiver_lock_ctrl xcvr_lane_checker u_chk (.pclk, .presetn, .psel, .penable,
    .prdata, .pready, .pslverr, .serial_out_pos, .serial_out_neg, .serial_in_pos,
    .rx_lock_source_select, .rx_word_valid, .rx_locked);

/* File: verif/remote_line_sender.sv */
// Model of the remote serial sender that feeds the lane's receive line.
`timescale 1ns/1ps
module remote_line_sender
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Pattern control.
    input wire logic toggle_en,
    input wire logic set_en,
    input wire logic set_level,
    // Differential line.
    output logic serial_in_pos,
    output logic serial_in_neg
);
    // Alternating bits give the most transitions; holding starves clock recovery on purpose.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            serial_in_pos <= 1'b0;
        else if (toggle_en)
            serial_in_pos <= !serial_in_pos;
        else if (set_en)
            serial_in_pos <= set_level;
    end
    // Both legs always driven; bits follow the shared reference timing.
    assign serial_in_neg = !serial_in_pos;
endmodule : remote_line_sender

/* File: verif/serial_transceiver_lock_ctrl_bench.sv */
// Self-checking testbench for the serial transceiver lane controller.
`timescale 1ns/1ps
module serial_transceiver_lock_ctrl_bench;
    import transceiver_pkg::*;
    localparam logic [SET_W-1:0] SW0 = 4'h5;
    localparam logic [SET_W-1:0] EM0 = 4'h3;
    localparam logic [SET_W-1:0] EQ0 = 4'h9;
    localparam logic [WORD_W-1:0] TX_WORD = 40'hA53C960F1B;
    localparam logic [WORD_W-1:0] ALL1 = 40'hFFFFFFFFFF;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic fabric_tx_clock, fabric_tx_ready, tx_line_invert, tx_word_clock;
    logic serial_out_pos, serial_out_neg, serial_in_pos, serial_in_neg;
    logic rx_lock_source_select, recovered_rx_clock, rx_word_valid, rx_locked;
    logic toggle_en, set_en, set_level;
    logic [WORD_W-1:0] fabric_tx_data, rx_word;
    logic [SET_W-1:0] swing_setting, emphasis_setting, rx_equalizer_setting;
    int fail_count, total_checks;
    mode_t tm [5] = '{MODE_X10, MODE_X16, MODE_X20, MODE_X32, MODE_X40};
    logic [CNT_W-1:0] tf [5] = '{FACTOR_10, FACTOR_16, FACTOR_20, FACTOR_32, FACTOR_40};

    serial_transceiver_lock_ctrl #(.LOCK_TRANSITIONS(20), .SWING_INIT(SW0), .EMPH_INIT(EM0),
        .EQ_INIT(EQ0)) dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .fabric_tx_clock, .fabric_tx_data,
        .fabric_tx_ready, .tx_line_invert, .tx_word_clock, .serial_out_pos, .serial_out_neg,
        .serial_in_pos, .serial_in_neg, .rx_lock_source_select, .recovered_rx_clock, .rx_word,
        .rx_word_valid, .rx_locked, .swing_setting, .emphasis_setting, .rx_equalizer_setting);
    remote_line_sender far_end (.pclk, .presetn, .toggle_en, .set_en, .set_level,
        .serial_in_pos, .serial_in_neg);

    ////////////////////////////////////////////////////////////////////////////
    // Shared checking, waiting and bus tasks.
    task automatic summarize();
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic give_up(input string nm);
        fail_count++;
        $display("[ERR] %s expected done seen timeout", nm);
        summarize();
    endtask : give_up
    // One setup and access; a release cycle follows so no signal is driven twice at one edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            give_up("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_valid(output int n);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (rx_word_valid !== 1'b1 && n < 200);
        if (n >= 200)
            give_up("rx word");
    endtask : wait_valid

    ////////////////////////////////////////////////////////////////////////////
    // Attribute start values, run-time writes and a refused address.
    task automatic regs_check();
        chk("swing init", 40'(SW0), 40'(swing_setting));
        chk("emph init", 40'(EM0), 40'(emphasis_setting));
        chk("eq init", 40'(EQ0), 40'(rx_equalizer_setting));
        apb(1'b1, SWING_ADDR, 32'h0000000C);
        apb(1'b1, EMPH_ADDR, 32'h0000000A);
        apb(1'b1, EQ_ADDR, 32'h00000006);
        chk("swing run", 40'hC, 40'(swing_setting));
        chk("emph run", 40'hA, 40'(emphasis_setting));
        apb(1'b0, EQ_ADDR, 32'h00000000);
        chk("eq read", 40'h6, 40'(rd));
        chk("eq pin", 40'h6, 40'(rx_equalizer_setting));
        apb(1'b1, 8'h18, 32'h0000000F);
        chk("unmapped err", 40'h1, 40'(err));
    endtask : regs_check
    // One word through the FIFO and serializer, bit 0 first, with optional leg swap.
    task automatic tx_check(input mode_t m, input logic pi, input logic ri, input int f);
        logic [WORD_W-1:0] got;
        logic inv;
        int n;
        int h;
        got = '0;
        h = 0;
        inv = pi | ri;
        apb(1'b1, CTRL_ADDR, {26'h0, 2'b00, ri, m});
        tx_line_invert <= pi;
        repeat (2 * f) @(posedge pclk);
        fabric_tx_data <= TX_WORD;
        fabric_tx_clock <= 1'b1;
        @(posedge pclk);
        chk("tx ready", 40'h1, 40'(fabric_tx_ready));
        fabric_tx_clock <= 1'b0;
        n = 0;
        while (serial_out_pos === inv && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100)
            give_up("tx start");
        for (int i = 0; i < f; i++)
        begin
            got[i] = serial_out_pos ^ inv;
            h += tx_word_clock;
            @(posedge pclk);
        end
        chk("tx bits", TX_WORD & (ALL1 >> (WORD_W - f)), got);
        chk("tx clock duty", 40'(f / 2), 40'(h));
    endtask : tx_check
    // Strobe held high until the FIFO refuses, then it must drain.
    task automatic fifo_check();
        int n;
        apb(1'b1, CTRL_ADDR, {26'h0, 3'b000, MODE_X40});
        fabric_tx_clock <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (fabric_tx_ready !== 1'b0 && n < 8);
        chk("fifo refuses", 40'h0, 40'(fabric_tx_ready));
        fabric_tx_clock <= 1'b0;
        repeat (200) @(posedge pclk);
        chk("fifo drains", 40'h1, 40'(fabric_tx_ready));
    endtask : fifo_check
    // Constant line: word rate and content, with the receive legs swapped or not.
    task automatic rx_check(input mode_t m, input logic ri, input int f);
        int n;
        int h;
        apb(1'b1, CTRL_ADDR, {26'h0, 1'b0, ri, 1'b0, m});
        wait_valid(n);
        wait_valid(n);
        wait_valid(n);
        chk("rx period", 40'(f), 40'(n));
        chk("rx word", ri ? 40'h0 : ALL1 >> (WORD_W - f), rx_word);
        // Any window of one word period holds exactly half a period of high clock.
        h = 0;
        repeat (f)
        begin
            @(posedge pclk);
            h += recovered_rx_clock;
        end
        chk("rx clock duty", 40'(f / 2), 40'(h));
    endtask : rx_check
    // Lock acquisition, gap tolerance, loss, fallback and forcing to the reference.
    task automatic lock_check();
        int n;
        apb(1'b1, CTRL_ADDR, 32'h00000000);
        toggle_en <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (rx_locked !== 1'b1 && n < 60);
        chk("lock time", 40'h1, 40'(n >= 19 && n <= 24));
        apb(1'b0, STATUS_ADDR, 32'h00000000);
        chk("status data", 40'h1, 40'(rd[2:0]));
        toggle_en <= 1'b0;
        repeat (70) @(posedge pclk);
        toggle_en <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("lock held", 40'h1, 40'(rx_locked));
        toggle_en <= 1'b0;
        repeat (90) @(posedge pclk);
        chk("lock lost", 40'h0, 40'(rx_locked));
        apb(1'b0, STATUS_ADDR, 32'h00000000);
        chk("status ref", 40'h2, 40'(rd[2:0]));
        toggle_en <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("relock", 40'h1, 40'(rx_locked));
        rx_lock_source_select <= 1'b1;
        repeat (40) @(posedge pclk);
        chk("forced unlock", 40'h0, 40'(rx_locked));
        apb(1'b0, STATUS_ADDR, 32'h00000000);
        chk("status forced", 40'h6, 40'(rd[2:0]));
        wait_valid(n);
        wait_valid(n);
        chk("forced sampling", 40'(FACTOR_10), 40'(n));
        rx_lock_source_select <= 1'b0;
        repeat (30) @(posedge pclk);
        chk("release relock", 40'h1, 40'(rx_locked));
        // Enable dropped just after a word pulse, so the frozen valid stays low.
        wait_valid(n);
        ce <= 1'b0;
        toggle_en <= 1'b0;
        repeat (90) @(posedge pclk);
        chk("frozen lock", 40'h1, 40'(rx_locked));
        ce <= 1'b1;
        toggle_en <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("thawed lock", 40'h1, 40'(rx_locked));
    endtask : lock_check

    ////////////////////////////////////////////////////////////////////////////
    // Clock source.
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Main sequence: reset for four cycles, then each scenario in turn.
    initial
    begin
        {presetn, psel, penable, pwrite, fabric_tx_clock, tx_line_invert} = '0;
        {rx_lock_source_select, toggle_en, set_en, set_level} = 4'h0;
        {paddr, pwdata, fabric_tx_data} = '0;
        ce = 1'b1;
        fail_count = 0;
        total_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs_check();
        for (int i = 0; i < 5; i++)
            tx_check(tm[i], i == 1, i == 2, int'(tf[i]));
        fifo_check();
        set_en <= 1'b1;
        set_level <= 1'b1;
        for (int i = 0; i < 5; i++)
            rx_check(tm[i], i[0], int'(tf[i]));
        set_en <= 1'b0;
        lock_check();
        summarize();
    end
endmodule : serial_transceiver_lock_ctrl_bench
